// File: acm_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH
`define ACM_OFF_CTRL 8'h00
`define ACM_OFF_ACTEN 8'h04
`define ACM_OFF_LEVEL 8'h08
`define ACM_OFF_HOLD 8'h0C
`define ACM_OFF_SWREQ 8'h10
`define ACM_OFF_LCDTMO 8'h14
`define ACM_OFF_SIOTMO 8'h18
`define ACM_OFF_STATUS 8'h1C
`define ACM_CTRL_EN 0
`define ACM_CTRL_COOP 1
`define ACM_CTRL_STOP 2
`define ACM_CTRL_DIV8 3
`define ACM_CTRL_HLTSTOP 4
`define ACM_CTRL_CARDON 5
`define ACM_CTRL_IMMED 6
`define ACM_CTRL_MDIV 8
`define ACM_SW_IDLE 0
`define ACM_SW_DOZE 1
`define ACM_SW_HALT 2
`define ACM_LVL_SDIV 8
`define ACM_CLK_NS 10
`define ACM_TICK_NS 1000
`define ACM_TICK_CYC (`ACM_TICK_NS / `ACM_CLK_NS)
`define ACM_RST_CTRL 10'h000
`define ACM_RST_ACTEN 7'h7F
`define ACM_RST_LVLMAX 4'hF
`define ACM_RST_SMPDIV 8'(`ACM_TICK_CYC - 1)
`define ACM_RST_HOLD 16'h0010
`define ACM_RST_TMO 16'h0000
`define ACM_SLOW4_LIM 3'h3
`define ACM_SLOW8_LIM 3'h7
`endif

// File: acm_pkg.sv
// shared types of the activity clock modulator
package acm_pkg;
   typedef enum logic [1:0] {
      ACM_FAST = 2'b00,
      ACM_SLOW = 2'b01,
      ACM_STOP = 2'b10
   } acm_mode_t;
endpackage

// File: acm_clk_if.sv
// carrier between the modulator core and the clock enable generator
`timescale 1ns/1ps
`default_nettype none
interface acm_clk_if;
   import acm_pkg::*;
   acm_mode_t mode;
   logic slow8;
   logic [1:0] main_div;
   logic cpu_en;
   logic lcd_en;
   modport ctl(output mode, slow8, main_div, input cpu_en, lcd_en);
   modport gen(input mode, slow8, main_div, output cpu_en, lcd_en);
endinterface
`default_nettype wire

// File: acm_clkgen.sv
// clock enable generator: main divisor, then fast, slow or stopped cpu
`timescale 1ns/1ps
`default_nettype none
`include "acm_defines.svh"
module acm_clkgen (
   input wire logic clock,
   input wire logic rst_b,
   acm_clk_if.gen cg
);
   import acm_pkg::*;
   typedef struct packed {
      logic [1:0] mcnt;
      logic [2:0] scnt;
      logic cpu_en;
      logic lcd_en;
   } acm_gen_t;
   acm_gen_t r_reg;
   acm_gen_t r_next;
   logic base;
   logic [2:0] lim;

   // base pulse every main_div+1 cycles feeds both cpu and display
   always_comb begin
      r_next = r_reg;
      r_next.cpu_en = 1'b0;
      r_next.lcd_en = 1'b0;
      base = (r_reg.mcnt == cg.main_div);
      lim = cg.slow8 ? `ACM_SLOW8_LIM : `ACM_SLOW4_LIM;
      if (base) begin
         r_next.mcnt = 2'h0;
         r_next.lcd_en = 1'b1;
         r_next.scnt = (r_reg.scnt >= lim) ? 3'h0 : r_reg.scnt + 3'h1;
      end else begin
         r_next.mcnt = r_reg.mcnt + 2'h1;
      end
      // slow passes one base pulse in four or eight
      unique case (cg.mode)
         ACM_FAST: r_next.cpu_en = base;
         ACM_SLOW: r_next.cpu_en = base && (r_reg.scnt == 3'h0);
         ACM_STOP: r_next.cpu_en = 1'b0;
         default: r_next.cpu_en = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign cg.cpu_en = r_reg.cpu_en;
   assign cg.lcd_en = r_reg.lcd_en;
endmodule
`default_nettype wire

// File: acm_core.sv
// activity driven cpu clock modulator with apb registers
// What this block does
// - seven activity indicators, each separately enabled
// - enabled activity pushes clock toward full speed
// - activity raises level if latch clear or on a sample tick
// - each sample tick clears latch, idle lowers
// - level zero slows or stops the clock
// - level at maximum gives full cpu speed
// - programmable maximum sets the hysteresis width
// - short monitor never touches long timeouts
// - cooperative mode admits software idle calls; doze and halt requests work in either mode
// - interrupt forces fast until inactivity hold expires
// - software lowers rate, forces doze, halts cpu
// - idle call runs slow until busy again
// - display timer cuts power, buffer stays reachable
// - serial idle timer stops the baud clock
// - card power in suspend; ring wakes
// - fast, slow by four or eight, stopped
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acm_defines.svh"
module acm_core (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic act_io_range,
   input wire logic act_video_wr,
   input wire logic irq_active,
   input wire logic act_serial_port,
   input wire logic act_card,
   input wire logic act_keyboard,
   input wire logic act_chip_sel,
   input wire logic serial_start,
   input wire logic halt_instruction,
   input wire logic suspend,
   input wire logic ring_indicator,
   output logic cpu_clk_en,
   output logic lcd_clk_en,
   output logic lcd_power,
   output logic baud_clk_run,
   output logic card_power,
   output logic wake
);
   import acm_pkg::*;

   typedef struct packed {
      logic [9:0] ctrl;
      logic [6:0] act_en;
      logic [3:0] lvl_max;
      logic [7:0] smp_div;
      logic [15:0] irq_hold;
      logic [15:0] lcd_tmo;
      logic [15:0] sio_tmo;
      logic [7:0] smp_cnt;
      logic tick;
      logic latch;
      logic [3:0] level;
      logic hw_fast;
      acm_mode_t mode;
      logic [15:0] hold_cnt;
      logic idle_req;
      logic halted;
      logic [15:0] lcd_cnt;
      logic lcd_on;
      logic [15:0] sio_cnt;
      logic baud_run;
      logic card_pwr;
      logic wake;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } acm_state_t;

   localparam acm_state_t ACM_RST = '{
      ctrl: `ACM_RST_CTRL,
      act_en: `ACM_RST_ACTEN,
      lvl_max: `ACM_RST_LVLMAX,
      smp_div: `ACM_RST_SMPDIV,
      irq_hold: `ACM_RST_HOLD,
      lcd_tmo: `ACM_RST_TMO,
      sio_tmo: `ACM_RST_TMO,
      mode: ACM_FAST,
      hw_fast: 1'b1,
      lcd_on: 1'b1,
      baud_run: 1'b1,
      card_pwr: 1'b1,
      default: '0
   };

   acm_state_t r_reg;
   acm_state_t r_next;
   logic [6:0] act_vec;
   logic act;
   logic wr;
   logic sw_idle_wr;
   logic sw_doze_wr;
   logic sw_halt_wr;
   logic [31:0] rd_data;
   logic rd_ok;

   acm_clk_if u_if();

   // saturating level step, never wraps at zero or maximum
   function automatic logic [3:0] lvl_step(input logic [3:0] v,
                                           input logic up,
                                           input logic [3:0] mx);
      if (up) begin
         lvl_step = (v >= mx) ? mx : v + 4'h1;
      end else begin
         lvl_step = (v == 4'h0) ? 4'h0 : v - 4'h1;
      end
   endfunction

   // inactivity countdown: event reloads, sample tick counts down
   function automatic logic [15:0] tstep(input logic [15:0] cnt,
                                         input logic ev,
                                         input logic tk,
                                         input logic [15:0] rl);
      if (ev) begin
         tstep = rl;
      end else if (tk && cnt != 16'h0) begin
         tstep = cnt - 16'h1;
      end else begin
         tstep = cnt;
      end
   endfunction

   // indicator gating; this path feeds nothing but the modulator
   assign act_vec = {act_chip_sel, act_keyboard, act_card,
                     act_serial_port, irq_active, act_video_wr,
                     act_io_range} & r_reg.act_en;
   assign act = |act_vec;

   // write takes effect at the edge where pready is sampled high
   assign wr = psel && penable && r_reg.pready && pwrite;
   assign sw_idle_wr = wr && paddr == `ACM_OFF_SWREQ &&
                       pwdata[`ACM_SW_IDLE] &&
                       r_reg.ctrl[`ACM_CTRL_COOP];
   assign sw_doze_wr = wr && paddr == `ACM_OFF_SWREQ &&
                       pwdata[`ACM_SW_DOZE];
   assign sw_halt_wr = wr && paddr == `ACM_OFF_SWREQ &&
                       pwdata[`ACM_SW_HALT];

   // read mux and address decode
   always_comb begin
      rd_data = 32'h0;
      rd_ok = 1'b1;
      unique case (paddr)
         `ACM_OFF_CTRL: rd_data[9:0] = r_reg.ctrl;
         `ACM_OFF_ACTEN: rd_data[6:0] = r_reg.act_en;
         `ACM_OFF_LEVEL: rd_data = {16'h0, r_reg.smp_div, 4'h0,
                                    r_reg.lvl_max};
         `ACM_OFF_HOLD: rd_data[15:0] = r_reg.irq_hold;
         `ACM_OFF_SWREQ: rd_data = 32'h0;
         `ACM_OFF_LCDTMO: rd_data[15:0] = r_reg.lcd_tmo;
         `ACM_OFF_SIOTMO: rd_data[15:0] = r_reg.sio_tmo;
         `ACM_OFF_STATUS: rd_data[12:0] = {r_reg.hw_fast, r_reg.halted,
                              r_reg.idle_req, r_reg.hold_cnt != 16'h0,
                              r_reg.baud_run, r_reg.lcd_on, r_reg.latch,
                              r_reg.mode, r_reg.level};
         default: rd_ok = 1'b0;
      endcase
   end

   // whole next state of the block
   always_comb begin
      r_next = r_reg;
      // apb: one wait cycle, answer registered
      r_next.pready = psel && penable && !r_reg.pready;
      r_next.pslverr = psel && penable && !r_reg.pready && !rd_ok;
      r_next.prdata = (psel && penable && !r_reg.pready && !pwrite) ?
                      rd_data : 32'h0;
      if (wr && rd_ok) begin
         unique case (paddr)
            `ACM_OFF_CTRL: r_next.ctrl = pwdata[9:0];
            `ACM_OFF_ACTEN: r_next.act_en = pwdata[6:0];
            `ACM_OFF_LEVEL: begin
               r_next.lvl_max = pwdata[3:0];
               r_next.smp_div = pwdata[`ACM_LVL_SDIV +: 8];
            end
            `ACM_OFF_HOLD: r_next.irq_hold = pwdata[15:0];
            `ACM_OFF_LCDTMO: r_next.lcd_tmo = pwdata[15:0];
            `ACM_OFF_SIOTMO: r_next.sio_tmo = pwdata[15:0];
            default: r_next.ctrl = r_reg.ctrl;
         endcase
      end
      // forced doze turns modulation on
      if (sw_doze_wr) begin
         r_next.ctrl[`ACM_CTRL_EN] = 1'b1;
      end

      // sample tick from the programmable prescaler
      r_next.tick = (r_reg.smp_cnt == r_reg.smp_div);
      r_next.smp_cnt = r_next.tick ? 8'h0 : r_reg.smp_cnt + 8'h1;

      // activity level and latch; a same-cycle event beats the clear
      // the tick empties the latch, so activity then opens a new interval
      r_next.latch = act || (r_reg.latch && !r_reg.tick);
      if (act && (!r_reg.latch || r_reg.tick)) begin
         r_next.level = lvl_step(r_reg.level, 1'b1,
                                 r_reg.lvl_max);
      end else if (r_reg.tick && !r_reg.latch && !act) begin
         r_next.level = lvl_step(r_reg.level, 1'b0,
                                 r_reg.lvl_max);
      end
      if (act && r_reg.ctrl[`ACM_CTRL_IMMED]) begin
         r_next.level = r_reg.lvl_max;
      end
      if (r_next.level > r_reg.lvl_max) begin
         r_next.level = r_reg.lvl_max;
      end
      // idle call predicts more idle: start from the bottom
      if (sw_idle_wr) begin
         r_next.level = 4'h0;
         r_next.idle_req = 1'b1;
      end else if (r_next.level == r_reg.lvl_max) begin
         r_next.idle_req = 1'b0;
      end

      // hysteresis: fast only at maximum, slow only at zero
      if (r_next.level == r_reg.lvl_max) begin
         r_next.hw_fast = 1'b1;
      end else if (r_next.level == 4'h0) begin
         r_next.hw_fast = 1'b0;
      end

      // interrupt hold reloads while the request line is active
      r_next.hold_cnt = tstep(r_reg.hold_cnt, irq_active, r_reg.tick,
                              r_reg.irq_hold);

      // halt until next interrupt; the interrupt wins
      if ((halt_instruction && r_reg.ctrl[`ACM_CTRL_HLTSTOP]) ||
          sw_halt_wr) begin
         r_next.halted = 1'b1;
      end
      if (irq_active) begin
         r_next.halted = 1'b0;
      end

      // clock choice, highest priority first
      if (r_next.halted) begin
         r_next.mode = ACM_STOP;
      end else if (!r_next.ctrl[`ACM_CTRL_EN]) begin
         r_next.mode = ACM_FAST;
      end else if (r_next.hold_cnt != 16'h0) begin
         r_next.mode = ACM_FAST;
      end else if (r_next.idle_req) begin
         r_next.mode = ACM_SLOW;
      end else if (r_next.hw_fast) begin
         r_next.mode = ACM_FAST;
      end else if (r_next.level == 4'h0 &&
                   r_next.ctrl[`ACM_CTRL_STOP]) begin
         r_next.mode = ACM_STOP;
      end else begin
         r_next.mode = ACM_SLOW;
      end

      // display power: gates panel only, buffer and registers stay live
      r_next.lcd_cnt = tstep(r_reg.lcd_cnt, act_video_wr, r_reg.tick,
                             r_reg.lcd_tmo);
      r_next.lcd_on = (r_reg.lcd_tmo == 16'h0) ||
                      (r_next.lcd_cnt != 16'h0);

      // baud clock idles after the serial timeout
      r_next.sio_cnt = tstep(r_reg.sio_cnt, serial_start, r_reg.tick,
                             r_reg.sio_tmo);
      r_next.baud_run = (r_reg.sio_tmo == 16'h0) ||
                        (r_next.sio_cnt != 16'h0);

      // card socket power and ring wake during suspend
      r_next.card_pwr = !suspend ||
                        r_reg.ctrl[`ACM_CTRL_CARDON];
      r_next.wake = suspend && r_reg.ctrl[`ACM_CTRL_CARDON] &&
                    ring_indicator;
   end

   // single state register, level zero and full speed at reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         r_reg <= ACM_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // rate selection handed to the enable generator
   assign u_if.mode = r_reg.mode;
   assign u_if.slow8 = r_reg.ctrl[`ACM_CTRL_DIV8];
   assign u_if.main_div = r_reg.ctrl[`ACM_CTRL_MDIV +: 2];

   acm_clkgen u_gen (
      .clock(clock),
      .rst_b(rst_b),
      .cg(u_if.gen)
   );

   // every output comes from a flop here or in the generator
   assign cpu_clk_en = u_if.cpu_en;
   assign lcd_clk_en = u_if.lcd_en;
   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign lcd_power = r_reg.lcd_on;
   assign baud_clk_run = r_reg.baud_run;
   assign card_power = r_reg.card_pwr;
   assign wake = r_reg.wake;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // checks next to the modulator logic
   chk_latch_set_on_act: assert property (act |=> r_reg.latch)
      else $error("latch not set after activity");
   chk_level_rises_once: assert property (
      act && !r_reg.latch && r_reg.level < r_reg.lvl_max &&
      !r_reg.ctrl[`ACM_CTRL_IMMED] && !sw_idle_wr && !wr
      |=> r_reg.level == $past(r_reg.level) + 4'h1)
      else $error("level did not rise by one");
   chk_level_rises_tick: assert property (
      act && r_reg.latch && r_reg.tick && r_reg.level < r_reg.lvl_max &&
      !r_reg.ctrl[`ACM_CTRL_IMMED] && !sw_idle_wr && !wr
      |=> r_reg.level == $past(r_reg.level) + 4'h1)
      else $error("level did not rise in a new interval");
   chk_level_falls_idle: assert property (
      r_reg.tick && !r_reg.latch && !act && r_reg.level != 4'h0 &&
      !sw_idle_wr && !wr
      |=> r_reg.level == $past(r_reg.level) - 4'h1 && !r_reg.latch)
      else $error("idle tick did not lower level");
   chk_full_at_max: assert property (
      r_reg.level == r_reg.lvl_max && !r_reg.halted
      |-> r_reg.mode == ACM_FAST)
      else $error("level at maximum but clock not fast");
   chk_slow_at_zero: assert property (
      r_reg.level == 4'h0 && r_reg.lvl_max != 4'h0 &&
      r_reg.ctrl[`ACM_CTRL_EN] && r_reg.hold_cnt == 16'h0
      |-> r_reg.mode != ACM_FAST)
      else $error("level zero but clock fast");
   chk_irq_goes_fast: assert property (
      irq_active && r_reg.irq_hold != 16'h0
      |=> r_reg.mode == ACM_FAST ##1 r_reg.mode == ACM_FAST)
      else $error("interrupt did not force full speed");
   chk_halt_stops_cpu: assert property (
      r_reg.halted |=> !cpu_clk_en)
      else $error("cpu clock ran while halted");
   chk_ring_wakes: assert property (
      suspend && ring_indicator && r_reg.ctrl[`ACM_CTRL_CARDON]
      |=> wake && card_power)
      else $error("ring did not wake with card powered");
   chk_level_in_range: assert property (
      !$past(wr) |-> r_reg.level <= r_reg.lvl_max)
      else $error("level above maximum");

   cov_reach_max: cover property (r_reg.level == r_reg.lvl_max &&
                                  r_reg.lvl_max != 4'h0);
   cov_clock_stop: cover property (r_reg.mode == ACM_STOP);
   cov_ring_wake: cover property (wake);
   cov_lcd_off: cover property ($fell(lcd_power));
endmodule
`default_nettype wire

// File: acm_partner.sv
// model of the cpu core and the peripheral activity sources
`timescale 1ns/1ps
`default_nettype none
module acm_partner (
   input wire logic clock,
   output logic [6:0] act,
   output logic halt_instruction,
   output logic serial_start,
   output logic ring_indicator
);
   // every source starts quiet
   initial begin
      act = 7'h00;
      halt_instruction = 1'b0;
      serial_start = 1'b0;
      ring_indicator = 1'b0;
   end
   // activity lines, bit order as in the enable register
   task automatic set_act(input logic [6:0] m);
      @(posedge clock);
      act <= m;
   endtask
   // one cycle of activity on the chosen sources
   task automatic pulse(input logic [6:0] m);
      set_act(m);
      set_act(7'h00);
   endtask
   // one cycle strobe: cpu halt when h, else serial start
   task automatic strobe(input logic h);
      @(posedge clock);
      halt_instruction <= h;
      serial_start <= !h;
      @(posedge clock);
      halt_instruction <= 1'b0;
      serial_start <= 1'b0;
   endtask
   // modem card raises its ring line and keeps it up
   task automatic ring();
      @(posedge clock);
      ring_indicator <= 1'b1;
   endtask
endmodule
`default_nettype wire

// File: acm_core_bench.sv
// self-checking bench of the activity clock modulator
`timescale 1ns/1ps
`default_nettype none
`include "acm_defines.svh"
`define ACM_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   fail_count++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
   end end
module acm_core_bench;
   logic clock, rst_b, psel, penable, pwrite, suspend;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, err;
   logic cpu_clk_en, lcd_clk_en, lcd_power, baud_clk_run;
   logic card_power, wake, halt_instruction, serial_start, ring_indicator;
   logic [6:0] act, m;
   logic [7:0] c;
   wire logic [3:0] outs;
   int fail_count = 0;
   int compares = 0;
   assign outs = {wake, card_power, baud_clk_run, lcd_power};
   acm_partner u_cpu (.clock(clock), .act(act),
      .halt_instruction(halt_instruction), .serial_start(serial_start),
      .ring_indicator(ring_indicator));
   acm_core u_dut (.clock(clock), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .act_io_range(act[0]), .act_video_wr(act[1]), .irq_active(act[2]),
      .act_serial_port(act[3]), .act_card(act[4]),
      .act_keyboard(act[5]), .act_chip_sel(act[6]),
      .serial_start(serial_start), .halt_instruction(halt_instruction),
      .suspend(suspend), .ring_indicator(ring_indicator),
      .cpu_clk_en(cpu_clk_en), .lcd_clk_en(lcd_clk_en),
      .lcd_power(lcd_power), .baud_clk_run(baud_clk_run),
      .card_power(card_power), .wake(wake));
   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // counts, verdict and end of run
   task automatic results();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // one apb transfer, request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // read and compare the masked word
   task automatic chk(input logic [7:0] a, input logic [31:0] mk, e,
                      input string nm);
      apb(1'b0, a, 32'h00000000);
      `ACM_CHK(nm, e, q & mk)
   endtask
   // poll status until the masked field matches, bounded
   task automatic wait_st(input logic [31:0] mk, e, input string nm);
      int n;
      n = 0;
      do begin
         apb(1'b0, `ACM_OFF_STATUS, 32'h00000000);
         n++;
      end while ((q & mk) !== e && n < 300);
      `ACM_CHK(nm, e, q & mk)
      if ((q & mk) !== e) results();
   endtask
   // wait for one output level, bounded
   task automatic wait_out(input int k, input logic v, input string nm);
      int n;
      n = 0;
      while (outs[k] !== v && n < 300) begin
         @(posedge clock);
         n++;
      end
      `ACM_CHK(nm, v, outs[k])
      if (outs[k] !== v) results();
   endtask
   // count enable pulses of the lcd (s=1) or cpu clock over n cycles
   task automatic cnt(input logic s, input int n);
      c = 8'h00;
      repeat (n) begin
         @(posedge clock);
         if ((s ? lcd_clk_en : cpu_clk_en) === 1'b1) c++;
      end
   endtask
   // main sequence; every wait above is bounded
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      suspend = 1'b0;
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      `ACM_CHK("outs", 4'h7, outs)
      chk(`ACM_OFF_CTRL, 32'hFFFFFFFF, 32'h00000000, "ctrl");
      chk(`ACM_OFF_ACTEN, 32'hFFFFFFFF, 32'h0000007F, "acten");
      chk(`ACM_OFF_LEVEL, 32'hFFFFFFFF, 32'h0000630F, "level");
      chk(`ACM_OFF_HOLD, 32'hFFFFFFFF, 32'h00000010, "hold");
      chk(`ACM_OFF_STATUS, 32'h0000003F, 32'h00000000, "st");
      chk(8'h20, 32'hFFFFFFFF, 32'h00000000, "unmapped");
      `ACM_CHK("slverr", 1'b1, err)
      $display("test reset done");
      // each source alone, several events in one interval count once
      wr(`ACM_OFF_LEVEL, 32'h0000FF0F);
      wr(`ACM_OFF_CTRL, 32'h00000001);
      wait_st(32'h0000003F, 32'h00000010, "idle");
      for (int i = 0; i < 7; i++) begin
         m = 7'h01 << i;
         wr(`ACM_OFF_ACTEN, {25'h0000000, m});
         u_cpu.pulse(~m);
         chk(`ACM_OFF_STATUS, 32'h0F, 32'h00, "masked");
         u_cpu.set_act(m);
         repeat (2) @(posedge clock);
         u_cpu.set_act(7'h00);
         chk(`ACM_OFF_STATUS, 32'h0F, 32'h01, "step");
         wait_st(32'h0000000F, 32'h00000000, "decay");
      end
      $display("test sources done");
      // rates: fast at maximum, slow by four and eight, stopped
      wr(`ACM_OFF_ACTEN, 32'h0000007F);
      wr(`ACM_OFF_LEVEL, 32'h00000302);
      u_cpu.set_act(7'h20);
      wait_st(32'h0000003F, 32'h00000002, "busy");
      cnt(1'b0, 40);
      `ACM_CHK("fast", 8'h28, c)
      u_cpu.set_act(7'h00);
      wait_st(32'h0000003F, 32'h00000010, "idle");
      cnt(1'b0, 80);
      `ACM_CHK("slow4", 8'h14, c)
      wr(`ACM_OFF_CTRL, 32'h00000009);
      cnt(1'b0, 8);
      cnt(1'b0, 80);
      `ACM_CHK("slow8", 8'h0A, c)
      wr(`ACM_OFF_CTRL, 32'h00000005);
      cnt(1'b0, 8);
      cnt(1'b0, 40);
      `ACM_CHK("stop", 8'h00, c)
      wr(`ACM_OFF_CTRL, 32'h00000001);
      u_cpu.pulse(7'h20);
      chk(`ACM_OFF_STATUS, 32'h30, 32'h10, "hyst");
      $display("test rates done");
      // immediate jump to full speed, software requests
      wr(`ACM_OFF_LEVEL, 32'h0000FF0F);
      wr(`ACM_OFF_CTRL, 32'h00000041);
      u_cpu.pulse(7'h01);
      chk(`ACM_OFF_STATUS, 32'h3F, 32'h0F, "jump");
      wr(`ACM_OFF_SWREQ, 32'h00000001);
      chk(`ACM_OFF_STATUS, 32'h0F, 32'h0F, "no coop");
      wr(`ACM_OFF_CTRL, 32'h00000043);
      wr(`ACM_OFF_SWREQ, 32'h00000001);
      chk(`ACM_OFF_STATUS, 32'h43F, 32'h410, "idle call");
      u_cpu.pulse(7'h01);
      chk(`ACM_OFF_STATUS, 32'h3F, 32'h0F, "busy again");
      wr(`ACM_OFF_CTRL, 32'h00000000);
      wr(`ACM_OFF_SWREQ, 32'h00000002);
      chk(`ACM_OFF_CTRL, 32'h01, 32'h01, "doze");
      wr(`ACM_OFF_CTRL, 32'h00000051);
      u_cpu.strobe(1'b1);
      chk(`ACM_OFF_STATUS, 32'h800, 32'h800, "halted");
      cnt(1'b0, 20);
      `ACM_CHK("halt clk", 8'h00, c)
      u_cpu.pulse(7'h04);
      chk(`ACM_OFF_STATUS, 32'h800, 32'h000, "resume");
      wr(`ACM_OFF_SWREQ, 32'h00000004);
      chk(`ACM_OFF_STATUS, 32'h800, 32'h800, "sw halt");
      u_cpu.pulse(7'h04);
      wr(`ACM_OFF_CTRL, 32'h00000301);
      cnt(1'b1, 8);
      cnt(1'b1, 80);
      `ACM_CHK("lcd div", 8'h14, c)
      $display("test software done");
      // interrupt hold keeps full speed only while it runs
      wr(`ACM_OFF_ACTEN, 32'h0000007B);
      wr(`ACM_OFF_HOLD, 32'h00000008);
      wr(`ACM_OFF_LEVEL, 32'h0000030F);
      wr(`ACM_OFF_CTRL, 32'h00000001);
      wait_st(32'h0000023F, 32'h00000010, "settled");
      u_cpu.pulse(7'h04);
      cnt(1'b0, 2);
      cnt(1'b0, 8);
      `ACM_CHK("irq fast", 8'h08, c)
      wait_st(32'h00000200, 32'h00000000, "hold end");
      cnt(1'b0, 8);
      cnt(1'b0, 80);
      `ACM_CHK("irq slow", 8'h14, c)
      $display("test hold done");
      // display and serial idle timers
      wr(`ACM_OFF_LCDTMO, 32'h00000002);
      wait_out(0, 1'b0, "lcd off");
      chk(`ACM_OFF_HOLD, 32'hFFFF, 32'h0008, "reach");
      u_cpu.pulse(7'h02);
      wait_out(0, 1'b1, "lcd on");
      wr(`ACM_OFF_SIOTMO, 32'h00000002);
      wait_out(1, 1'b0, "baud stop");
      u_cpu.strobe(1'b0);
      wait_out(1, 1'b1, "baud run");
      $display("test timers done");
      // card socket power in suspend and ring wake
      @(posedge clock);
      suspend <= 1'b1;
      wait_out(2, 1'b0, "card off");
      wr(`ACM_OFF_CTRL, 32'h00000021);
      wait_out(2, 1'b1, "card on");
      u_cpu.ring();
      wait_out(3, 1'b1, "wake");
      $display("test card done");
      results();
   end
endmodule
`default_nettype wire
